/* tmw_cfg.svh */
// Offsets, field positions, reset values and divider masks of the timer.
`ifndef TMW_CFG_SVH
`define TMW_CFG_SVH
`define TMW_OFS_CTL 8'h00
`define TMW_OFS_CNT 8'h04
`define TMW_OFS_CMP 8'h08
`define TMW_OFS_FLG 8'h0C
`define TMW_OFS_AUX 8'h10
`define TMW_FLG_OVF 0
`define TMW_FLG_CMP 1
`define TMW_AUX_DIR 0
`define TMW_AUX_PORT 1
`define TMW_AUX_ASYNC 2
`define TMW_RST_CTL 8'h00
`define TMW_RST_CNT 8'h00
`define TMW_RST_CMP 8'h00
`define TMW_RST_AUX 3'h0
`define TMW_MAX 8'hFF
`define TMW_MAX_M1 8'hFE
`define TMW_MASK_8 10'h007
`define TMW_MASK_32 10'h01F
`define TMW_MASK_64 10'h03F
`define TMW_MASK_128 10'h07F
`define TMW_MASK_256 10'h0FF
`define TMW_MASK_1024 10'h3FF
`define TMW_RESP_OKAY 2'h0
`define TMW_RESP_SLVERR 2'h2
`endif

/* tmw_pkg.sv */
// Types shared by the timer waveform block.
package tmw_pkg;
  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic force_strobe;
    logic wave_lo;
    logic [1:0] output_action_select;
    logic wave_hi;
    logic [2:0] clock_source_select;
  } tmw_ctl_type;
  // Waveform modes as {wave_hi, wave_lo}.
  typedef enum logic [1:0] {
    TMW_NORMAL = 2'h0,
    TMW_PHASE = 2'h1,
    TMW_CTC = 2'h2,
    TMW_FAST = 2'h3
  } tmw_mode_type;
  // Compare output pin as two signals.
  typedef struct packed {
    logic level;
    logic oe_n;
  } tmw_pin_type;
endpackage

/* tmw_timer.sv */
// Eight-bit timer with compare output waveform generation and AXI4-Lite.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tmw_cfg.svh"
module tmw_timer (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data channels.
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response channel.
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read channels.
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Timer oscillator tick, synchronous to aclk.
  input wire logic osc_tick,
  // Compare output pin and flag levels.
  output tmw_pkg::tmw_pin_type compare_output_pin,
  output logic overflow_flag,
  output logic compare_flag
);
  import tmw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register bus.

  tmw_ctl_type ctl_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cmp_buf_reg;
  logic [7:0] cmp_act_reg;
  logic [1:0] flg_reg;
  logic [2:0] aux_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_en_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_wr;
  logic wr_ctl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flg;
  logic wr_aux;

  // True for the five mapped word addresses.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `TMW_OFS_CTL) || (a == `TMW_OFS_CNT) ||
      (a == `TMW_OFS_CMP) || (a == `TMW_OFS_FLG) || (a == `TMW_OFS_AUX);
  endfunction

  // Address and data are taken in either order; the write fires once both
  // are held, so the response lags the later one by one cycle.
  assign s_awready = !aw_got_reg && !bvalid_reg;
  assign s_wready = !w_got_reg && !bvalid_reg;
  assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
  assign wr_ctl = do_wr && w_en_reg && (aw_addr_reg == `TMW_OFS_CTL);
  assign wr_cnt = do_wr && w_en_reg && (aw_addr_reg == `TMW_OFS_CNT);
  assign wr_cmp = do_wr && w_en_reg && (aw_addr_reg == `TMW_OFS_CMP);
  assign wr_flg = do_wr && w_en_reg && (aw_addr_reg == `TMW_OFS_FLG);
  assign wr_aux = do_wr && w_en_reg && (aw_addr_reg == `TMW_OFS_AUX);
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = !rvalid_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rdata = rdata_reg;
  assign s_rresp = rresp_reg;

  // Write channel capture and response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_en_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TMW_RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_wdata[7:0];
        w_en_reg <= s_wstrb[0];
      end
      if (do_wr)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? `TMW_RESP_OKAY : `TMW_RESP_SLVERR;
      end
      else if (s_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Read data; the force strobe always reads back as zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `TMW_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(s_araddr) ? `TMW_RESP_OKAY : `TMW_RESP_SLVERR;
      case (s_araddr)
        `TMW_OFS_CTL: rdata_reg <= {24'h0, 1'b0, ctl_reg[6:0]};
        `TMW_OFS_CNT: rdata_reg <= {24'h0, cnt_reg};
        `TMW_OFS_CMP: rdata_reg <= {24'h0, cmp_buf_reg};
        `TMW_OFS_FLG: rdata_reg <= {30'h0, flg_reg};
        `TMW_OFS_AUX: rdata_reg <= {29'h0, aux_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
    else if (s_rready)
      rvalid_reg <= 1'b0;
  end

  // Control and auxiliary registers; the strobe bit is never stored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_reg <= `TMW_RST_CTL;
      aux_reg <= `TMW_RST_AUX;
    end
    else
    begin
      if (wr_ctl)
        ctl_reg <= {1'b0, w_data_reg[6:0]};
      if (wr_aux)
        aux_reg <= w_data_reg[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and timer tick.

  tmw_mode_type mode;
  logic fast;
  logic phase;
  logic pwm;
  logic src_tick;
  logic tick;
  logic [9:0] presc_reg;
  logic [9:0] div_mask;

  // Divider mask per clock select code; the tick fires when the masked
  // prescaler bits are all ones.
  function automatic logic [9:0] sel_mask(input logic [2:0] cs);
    case (cs)
      3'h2: sel_mask = `TMW_MASK_8;
      3'h3: sel_mask = `TMW_MASK_32;
      3'h4: sel_mask = `TMW_MASK_64;
      3'h5: sel_mask = `TMW_MASK_128;
      3'h6: sel_mask = `TMW_MASK_256;
      3'h7: sel_mask = `TMW_MASK_1024;
      default: sel_mask = 10'h000;
    endcase
  endfunction

  assign mode = tmw_mode_type'({ctl_reg.wave_hi, ctl_reg.wave_lo});
  assign fast = (mode == TMW_FAST);
  assign phase = (mode == TMW_PHASE);
  assign pwm = fast || phase;
  // The oscillator tick replaces the I/O clock as the counting source.
  assign src_tick = aux_reg[`TMW_AUX_ASYNC] ? osc_tick : 1'b1;
  assign div_mask = sel_mask(ctl_reg.clock_source_select);
  assign tick = src_tick && (ctl_reg.clock_source_select != 3'h0) &&
    ((presc_reg & div_mask) == div_mask);

  // Free-running prescaler shared by all divide ratios.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      presc_reg <= 10'h000;
    else if (src_tick)
      presc_reg <= presc_reg + 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, direction and compare buffer.

  logic down_reg;
  logic blk_reg;
  logic [7:0] top_v;
  logic match;
  logic at_max;
  logic ovf_set;
  logic force_hit;

  assign top_v = (mode == TMW_CTC) ? cmp_act_reg : `TMW_MAX;
  assign at_max = (cnt_reg == `TMW_MAX);
  assign match = tick && !blk_reg && (cnt_reg == cmp_act_reg);
  assign ovf_set = tick && (phase ? (down_reg && cnt_reg == 8'h00)
    : at_max);
  // Both non-PWM modes, normal and clear-on-compare, have the low mode bit
  // clear, so that bit alone decides whether the strobe may act.
  assign force_hit = wr_ctl && w_data_reg[7] && !w_data_reg[6];

  // Counter steps; a software write takes priority over a tick.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= `TMW_RST_CNT;
    else if (wr_cnt)
      cnt_reg <= w_data_reg;
    else if (tick)
    begin
      if (phase)
      begin
        if (down_reg)
          cnt_reg <= (cnt_reg == 8'h00) ? 8'h01 : cnt_reg - 8'h01;
        else
          cnt_reg <= at_max ? `TMW_MAX_M1 : cnt_reg + 8'h01;
      end
      else if (cnt_reg == top_v)
        cnt_reg <= 8'h00;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Count direction; only phase mode ever counts down.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      down_reg <= 1'b0;
    else if (!phase)
      down_reg <= 1'b0;
    else if (tick && !down_reg && at_max)
      down_reg <= 1'b1;
    else if (tick && down_reg && cnt_reg == 8'h00)
      down_reg <= 1'b0;
  end

  // A counter write masks the match on the next tick only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      blk_reg <= 1'b0;
    else if (wr_cnt)
      blk_reg <= 1'b1;
    else if (tick)
      blk_reg <= 1'b0;
  end

  // The PWM modes load the active compare value at fixed points so a
  // mid-period write cannot produce a glitch pulse.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_buf_reg <= `TMW_RST_CMP;
      cmp_act_reg <= `TMW_RST_CMP;
    end
    else
    begin
      if (wr_cmp)
        cmp_buf_reg <= w_data_reg;
      if (wr_cmp && !pwm)
        cmp_act_reg <= w_data_reg;
      else if (tick && at_max && fast)
        cmp_act_reg <= cmp_buf_reg;
      else if (tick && at_max && phase && !down_reg)
        cmp_act_reg <= cmp_buf_reg;
      // Without this a value buffered under PWM would stay stale after a
      // switch to a non-PWM mode, leaving the old top in force.
      else if (!pwm)
        cmp_act_reg <= cmp_buf_reg;
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flg_reg <= 2'h0;
    else
    begin
      flg_reg[`TMW_FLG_OVF] <= ovf_set ||
        (flg_reg[`TMW_FLG_OVF] && !(wr_flg && w_data_reg[`TMW_FLG_OVF]));
      flg_reg[`TMW_FLG_CMP] <= match ||
        (flg_reg[`TMW_FLG_CMP] && !(wr_flg && w_data_reg[`TMW_FLG_CMP]));
    end
  end

  assign overflow_flag = flg_reg[`TMW_FLG_OVF];
  assign compare_flag = flg_reg[`TMW_FLG_CMP];

  ////////////////////////////////////////////////////////////////////////
  // Waveform generator and pin.

  logic oc_reg;
  logic [1:0] act;
  logic inv;
  tmw_pin_type pin_reg;

  assign act = ctl_reg.output_action_select;
  assign inv = act[0];

  // Output compare level. Action 1 in PWM modes is reserved and does nothing.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oc_reg <= 1'b0;
    else if (force_hit)
    begin
      case (w_data_reg[5:4])
        2'h1: oc_reg <= !oc_reg;
        2'h2: oc_reg <= 1'b0;
        2'h3: oc_reg <= 1'b1;
        default: oc_reg <= oc_reg;
      endcase
    end
    else if (fast && act[1])
    begin
      if (tick && at_max)
        oc_reg <= !inv;
      else if (match && cmp_act_reg != `TMW_MAX)
        oc_reg <= inv;
    end
    else if (phase && act[1])
    begin
      if (tick && at_max && !down_reg)
        oc_reg <= (cmp_buf_reg == `TMW_MAX) ? !inv : inv;
      else if (match)
        oc_reg <= (!down_reg || cnt_reg == 8'h00) ? inv : !inv;
    end
    else if (!pwm && match)
    begin
      case (act)
        2'h1: oc_reg <= !oc_reg;
        2'h2: oc_reg <= 1'b0;
        2'h3: oc_reg <= 1'b1;
        default: oc_reg <= oc_reg;
      endcase
    end
  end

  // Pin mux: compare output overrides the port bit when any action is set,
  // but only the direction bit turns the driver on.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_reg <= 2'h1;
    else
    begin
      pin_reg.level <= (act != 2'h0) ? oc_reg : aux_reg[`TMW_AUX_PORT];
      pin_reg.oe_n <= !aux_reg[`TMW_AUX_DIR];
    end
  end

  assign compare_output_pin = pin_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fast_ovf;
    (fast && tick && at_max) |=> overflow_flag;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast ovf");

  property p_fast_clear;
    (fast && tick && at_max && !wr_cnt) |=> (cnt_reg == 8'h00);
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("clr");

  property p_turn;
    (phase && tick && at_max && !down_reg && !wr_cnt && !wr_ctl)
      |=> (down_reg && cnt_reg == `TMW_MAX_M1);
  endproperty
  a_turn: assert property (p_turn) else $error("turn at max");

  property p_pc_ovf;
    (phase && tick && down_reg && cnt_reg == 8'h00) |=> overflow_flag;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("pc ovf");

  property p_block;
    (tick && blk_reg && !compare_flag) |=> !compare_flag;
  endproperty
  a_block: assert property (p_block) else $error("blocked match");

  property p_stop;
    (ctl_reg.clock_source_select == 3'h0) |-> !tick;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped tick");

  property p_oe;
    !aux_reg[`TMW_AUX_DIR] |=> compare_output_pin.oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven");

  property p_fast_max;
    (fast && !wr_ctl && act == 2'h2 && cmp_act_reg == `TMW_MAX && tick &&
      cmp_buf_reg == `TMW_MAX && at_max) |=> oc_reg ##1 oc_reg;
  endproperty
  a_fast_max: assert property (p_fast_max) else $error("max lvl");

  property p_dbuf;
    (fast && $past(fast) && !$past(tick && at_max)) |-> $stable(cmp_act_reg);
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("buffer load");

  property p_pc_low;
    (phase && !wr_ctl && act == 2'h2 && cmp_act_reg == 8'h00 &&
      cmp_buf_reg == 8'h00 && tick) |=> !oc_reg;
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("pc low");
endmodule

/* tmw_load.sv */
// Load on the compare output pin: counts high cycles and rising edges.
`timescale 1ns/1ns
module tmw_load
  import tmw_pkg::*;
(
  // Clock and window restart.
  input wire logic aclk,
  input wire logic clr,
  // Pin as driven by the timer.
  input wire tmw_pkg::tmw_pin_type pin,
  // Measurements over the current window.
  output logic [15:0] high_cnt,
  output logic [15:0] rise_cnt
);
  logic pin_wire;
  logic prev_reg;
  ////////////////////////////////////////////////////////////////////////
  // A released pin sits at the pull-down level, never at its last value.
  assign pin_wire = pin.oe_n ? 1'b0 : pin.level;
  // Counters restart whenever the bench opens a new window.
  always_ff @(posedge aclk)
  begin
    prev_reg <= pin_wire;
    if (clr)
    begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end
    else
    begin
      high_cnt <= high_cnt + {15'h0000, pin_wire};
      rise_cnt <= rise_cnt + {15'h0000, pin_wire & ~prev_reg};
    end
  end
endmodule

/* tmw_timer_tb_top.sv */
// Self-checking bench for the timer waveform block.
`timescale 1ns/1ns
`include "tmw_cfg.svh"
module tmw_timer_tb_top;
  import tmw_pkg::*;
  logic aclk, aresetn, clr;
  logic osc_tick = 1'b0;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic overflow_flag, compare_flag;
  tmw_pin_type pin;
  logic [15:0] high_cnt, rise_cnt;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Device under test and the load on its pin.
  tmw_timer tmw_timer_i (.aclk, .aresetn, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .osc_tick,
    .compare_output_pin(pin), .overflow_flag, .compare_flag);
  tmw_load tmw_load_i (.aclk, .clr, .pin, .high_cnt, .rise_cnt);
  // Clock at 50 MHz.
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Oscillator tick pulses every second clock, apart from the prescaler.
  always @(posedge aclk)
  begin
    osc_tick <= ~osc_tick;
  end
  // The whole sequence needs about 64600 cycles; this cuts hangs.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Compares one value with four-state equality.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [1:0] er);
    logic ta;
    logic tw;
    logic [1:0] r;
    s_awaddr <= a;
    s_wdata <= {24'h000000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_awvalid & s_awready;
      tw = s_wvalid & s_wready;
      @(posedge aclk);
      if (ta)
        s_awvalid <= 1'b0;
      if (tw)
        s_wvalid <= 1'b0;
    end
    while ((s_awvalid & ~ta) | (s_wvalid & ~tw));
    do
    begin
      @(negedge aclk);
      ta = s_bvalid;
      r = s_bresp;
      @(posedge aclk);
    end
    while (!ta);
    s_bready <= 1'b0;
    @(posedge aclk);
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Read: address held until taken, rready held until rvalid.
  task automatic axi_read(input logic [7:0] a, input logic [7:0] ed,
                          input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_arvalid & s_arready;
      @(posedge aclk);
    end
    while (!t);
    s_arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
    end
    while (!t);
    s_rready <= 1'b0;
    @(posedge aclk);
    check("rdata", {24'h000000, ed}, d);
    check("rresp", {30'h0, er}, {30'h0, r});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values, then an unmapped read and write.
  task automatic reset_case();
    check("oe_n at reset", 1, pin.oe_n);
    for (int a = 0; a <= 16; a += 4)
      axi_read(a[7:0], 8'h00, `TMW_RESP_OKAY);
    axi_read(8'h14, 8'h00, `TMW_RESP_SLVERR);
    axi_write(8'h14, 8'h5A, `TMW_RESP_SLVERR);
  endtask
  // Forced actions on a stopped timer: only non-PWM modes react.
  task automatic force_case();
    axi_write(`TMW_OFS_AUX, 8'h01, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CTL, 8'hB8, `TMW_RESP_OKAY);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("forced set", 1, pin.level);
    check("oe_n", 0, pin.oe_n);
    check("no flag", 0, compare_flag);
    @(posedge aclk);
    axi_read(`TMW_OFS_CTL, 8'h38, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CTL, 8'hA8, `TMW_RESP_OKAY);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("forced clear", 0, pin.level);
    @(posedge aclk);
    axi_write(`TMW_OFS_CTL, 8'hF8, `TMW_RESP_OKAY);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("pwm force ignored", 0, pin.level);
    @(posedge aclk);
    axi_read(`TMW_OFS_CNT, 8'h00, `TMW_RESP_OKAY);
  endtask
  // Sets a mode, lets it settle, then measures two whole periods.
  task automatic pwm_case(input logic [7:0] ctl, input logic [7:0] cmp,
                          input logic [7:0] aux, input int period,
                          input int hi, input int rises);
    axi_write(`TMW_OFS_AUX, aux, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CMP, cmp, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CTL, ctl, `TMW_RESP_OKAY);
    repeat (2 * period + 8) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (2 * period) @(posedge aclk);
    @(negedge aclk);
    check("high cycles", 2 * hi, {16'h0000, high_cnt});
    check("rising edges", 2 * rises, {16'h0000, rise_cnt});
    @(posedge aclk);
  endtask
  // Clears both flags and expects each to come back within one period.
  task automatic flag_case(input int period);
    axi_write(`TMW_OFS_FLG, 8'h03, `TMW_RESP_OKAY);
    repeat (period + 4) @(posedge aclk);
    @(negedge aclk);
    check("overflow flag", 1, overflow_flag);
    check("compare flag", 1, compare_flag);
    @(posedge aclk);
    axi_read(`TMW_OFS_FLG, 8'h03, `TMW_RESP_OKAY);
  endtask
  // A counter write on a stopped timer that lands on the compare value
  // must not raise the compare flag at the first tick after restart.
  task automatic block_case();
    axi_write(`TMW_OFS_CTL, 8'h00, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CMP, 8'h05, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CNT, 8'h05, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_FLG, 8'h03, `TMW_RESP_OKAY);
    axi_write(`TMW_OFS_CTL, 8'h07, `TMW_RESP_OKAY);
    repeat (1030) @(posedge aclk);
    @(negedge aclk);
    check("blocked match", 0, compare_flag);
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    aresetn = 1'b0;
    clr = 1'b0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h00000000;
    s_wstrb = 4'hF;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_case();
    force_case();
    pwm_case(8'h69, 8'h40, 8'h01, 256, 65, 1);
    flag_case(256);
    pwm_case(8'h79, 8'h40, 8'h01, 256, 191, 1);
    pwm_case(8'h69, 8'h00, 8'h01, 256, 1, 1);
    pwm_case(8'h69, 8'hFF, 8'h01, 256, 256, 0);
    pwm_case(8'h79, 8'hFF, 8'h01, 256, 0, 0);
    pwm_case(8'h69, 8'hFF, 8'h00, 256, 0, 0);
    pwm_case(8'h6A, 8'h40, 8'h01, 2048, 520, 1);
    pwm_case(8'h6B, 8'h40, 8'h01, 8192, 2080, 1);
    pwm_case(8'h69, 8'h40, 8'h05, 512, 130, 1);
    pwm_case(8'h61, 8'h40, 8'h01, 510, 128, 1);
    flag_case(510);
    pwm_case(8'h71, 8'h40, 8'h01, 510, 382, 1);
    pwm_case(8'h61, 8'h00, 8'h01, 510, 0, 0);
    pwm_case(8'h61, 8'hFF, 8'h01, 510, 510, 0);
    pwm_case(8'h71, 8'hFF, 8'h01, 510, 0, 0);
    pwm_case(8'h19, 8'h09, 8'h01, 160, 80, 8);
    pwm_case(8'h19, 8'hFF, 8'h01, 512, 256, 1);
    flag_case(256);
    block_case();
    print_verdict();
  end
endmodule
